// File: core/lgc_defines.svh
// Purpose: Offsets, field positions, reset values and masks of the line
//          interface configuration bank.
// Assumes: Eight-bit host data, eight-bit register addresses.
// Notes:   Definitions only; included by bare name.
`ifndef LGC_DEFINES_SVH
`define LGC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LGC_ADDR_SW_RESET 8'h01
`define LGC_ADDR_CH1_TERM 8'h02
`define LGC_ADDR_CH1_JITTER 8'h03
`define LGC_ADDR_GLOBAL 8'h20
`define LGC_ADDR_IRQ_SRC 8'h21
`define LGC_ADDR_CH2_TERM 8'h22
`define LGC_ADDR_CH2_JITTER 8'h23

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define LGC_RST_SW_RESET 8'h00
`define LGC_RST_GLOBAL 8'h04
`define LGC_RST_TERM 8'h00
`define LGC_RST_JITTER 8'h20
`define LGC_MASK_GLOBAL 8'hDF
`define LGC_MASK_TERM 8'h3F
`define LGC_MASK_JITTER 8'h3F
`define LGC_MASK_IRQ_SRC 8'h03
`define LGC_KEEP_GLOBAL 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LGC_MON_MSB 7
`define LGC_MON_LSB 6
`define LGC_STD_BIT 4
`define LGC_BCAST_BIT 3
`define LGC_IRQ_DIS_BIT 2
`define LGC_PIN_MSB 1
`define LGC_PIN_LSB 0
`define LGC_TX_TERM_MSB 5
`define LGC_TX_TERM_LSB 3
`define LGC_RX_TERM_MSB 2
`define LGC_RX_TERM_LSB 0
`define LGC_JITTER_LIMIT_MODE_BIT 5
`define LGC_JA_PLACE_MSB 4
`define LGC_JA_PLACE_LSB 3
`define LGC_JA_DEPTH_MSB 2
`define LGC_JA_DEPTH_LSB 1
`define LGC_JA_BW_BIT 0

// ----------------------------------------
// Elastic buffer depths in bits
// ----------------------------------------
`define LGC_DEPTH_128 8'h80
`define LGC_DEPTH_64 8'h40
`define LGC_DEPTH_32 8'h20

`endif

// File: core/lgc_pkg.sv
// Purpose: Types shared by the configuration bank and its pin driver.
// Assumes: Nothing beyond the defines header.
// Notes:   Enums carry no explicit codes.
package lgc_pkg;

	// ----------------------------------------
	// Decoded settings
	// ----------------------------------------
	typedef enum logic [2:0] {LGC_TERM_75, LGC_TERM_120, LGC_TERM_100, LGC_TERM_110,
		LGC_TERM_EXT} lgc_term_t;
	typedef enum logic [1:0] {LGC_JA_OFF, LGC_JA_TX, LGC_JA_RX} lgc_ja_place_t;
	typedef enum logic [1:0] {LGC_BW_E1_6P8, LGC_BW_T1_5, LGC_BW_E1_0P9,
		LGC_BW_T1_1P25} lgc_ja_corner_t;
	typedef enum logic [1:0] {LGC_MON_NORMAL, LGC_MON_RX2, LGC_MON_TX2} lgc_monitor_t;
	typedef enum logic [1:0] {LGC_PIN_OD_LOW, LGC_PIN_PP_LOW, LGC_PIN_PP_HIGH} lgc_pin_style_t;

	// One channel's decoded configuration
	typedef struct packed {
		lgc_term_t txTerm;
		lgc_term_t rxTerm;
		lgc_ja_place_t jaPlace;
		logic [7:0] jaDepthBits;
		lgc_ja_corner_t jaCorner;
		logic jaLimit;
	} lgc_chan_cfg_t;

	// Host request
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wrData;
	} lgc_host_req_t;

	// Whole state of the bank
	typedef struct packed {
		logic [7:0] globalCfg;
		logic [1:0][7:0] term;
		logic [1:0][7:0] jitter;
		logic [7:0] rdData;
		logic rdValid;
		logic [1:0] drvHiZ;
		logic swResetPulse;
		lgc_chan_cfg_t [1:0] chCfg;
		lgc_monitor_t monitor;
		logic t1Mode;
		logic irqDisable;
		lgc_pin_style_t pinStyle;
	} lgc_state_t;

	// Whole state of the interrupt pin driver
	typedef struct packed {
		logic active;
		logic pinOut;
		logic pinOe_n;
	} lgc_pin_state_t;

endpackage : lgc_pkg

// File: core/lgc_irq_pin.sv
// Purpose: Interrupt pin driver with global disable and selectable style.
// Assumes: Channel requests already pass their own mask bits.
// Notes:   Output enable is low while the pin is driven.
`timescale 1ns/1ps
`default_nettype none

module lgc_irq_pin (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic [1:0] chIrq,
	input wire logic irqDisable,
	input wire lgc_pkg::lgc_pin_style_t pinStyle,
	// Pin
	output logic pinOut,
	output logic pinOe_n
);

	lgc_pkg::lgc_pin_state_t st;
	lgc_pkg::lgc_pin_state_t next_st;

	// Next pin level; open drain only ever pulls low
	always_comb begin
		next_st = st;
		next_st.active = (|chIrq) && !irqDisable; // see R9
		unique case (pinStyle) // see R10
			lgc_pkg::LGC_PIN_OD_LOW: begin
				next_st.pinOut = 1'b0;
				next_st.pinOe_n = !next_st.active;
			end
			lgc_pkg::LGC_PIN_PP_LOW: begin
				next_st.pinOut = !next_st.active;
				next_st.pinOe_n = 1'b0;
			end
			lgc_pkg::LGC_PIN_PP_HIGH: begin
				next_st.pinOut = next_st.active;
				next_st.pinOe_n = 1'b0;
			end
			default: begin
				next_st.pinOut = 1'b1;
				next_st.pinOe_n = 1'b1;
			end
		endcase
	end

	// State register; pin released at reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{active: 1'b0, pinOut: 1'b1, pinOe_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign pinOut = st.pinOut;
	assign pinOe_n = st.pinOe_n;

	default clocking cbPin @(posedge clk); endclocking
	default disable iff (rst);

	a_irq_global_off: assert property (irqDisable |=> !st.active) // see R9
		else $error("interrupt active while globally disabled");
	a_pp_high_level: assert property (pinStyle == lgc_pkg::LGC_PIN_PP_HIGH && |chIrq // see R10
		&& !irqDisable |=> pinOut && !pinOe_n)
		else $error("push-pull high pin not asserted");
	a_od_pin_release: assert property (pinStyle == lgc_pkg::LGC_PIN_OD_LOW // see R10
		|=> !pinOut && (pinOe_n == !st.active))
		else $error("open-drain pin drives high or wrong enable");

endmodule : lgc_irq_pin

`default_nettype wire

// File: core/lgc_config.sv
// Purpose: Global and per-channel configuration bank of a dual line interface.
// Assumes: Host strobes are one-cycle and synchronous to clk.
// Notes:   Read data return one cycle after the read strobe.
//
// How it works
// R1: Any write to the software reset offset restores defaults and default port states.
// R2: Software reset register stores nothing; it always reads its fixed value.
// R3: After a software reset all line drivers are held high impedance.
// R4: Line standard bit survives a software reset unchanged.
// R5: Monitor field routes receiver 1 to channel 2 receive or transmit path.
// R6: Global bit 4 selects E1 at 0, T1/J1 at 1, for both channels.
// R7: Host waits 50 us after changing line standard before other accesses.
// R8: With broadcast set, a channel register write lands in both channels.
// R9: Global disable bit, reset to 1, blocks all channel interrupts.
// R10: Pin style selects open drain low, push-pull low or push-pull high.
// R11: Source register bit n reads 0 when channel n+1 interrupts.
// R12: Transmit termination code selects 75/120/100/110 ohms or external, E1 only.
// R13: Receive termination code selects 75/120/100/110 ohms or external resistors.
// R14: Termination and jitter registers exist per channel at 02H/03H and 22H/23H.
// R15: Jitter placement: unused, transmit path or receive path.
// R16: Jitter depth: 128, 64 or 32 bits of elastic buffer.
// R17: Bandwidth bit selects jitter corner, depending on line standard.
// R18: Limit bit, reset to 1, selects jitter limit mode.
// R19: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "lgc_defines.svh"

module lgc_config (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host register port
	input wire logic [7:0] hostAddr,
	input wire logic hostWr,
	input wire logic hostRd,
	input wire logic [7:0] hostWrData,
	output logic [7:0] hostRdData,
	output logic hostRdValid,
	// Channel interrupt requests, already masked per source
	input wire logic [1:0] chIrq,
	// Decoded configuration
	output lgc_pkg::lgc_chan_cfg_t [1:0] chanCfg,
	output lgc_pkg::lgc_monitor_t monitorRoute,
	output logic t1Mode,
	output logic [1:0] drvHiZ,
	output logic swResetPulse,
	// Interrupt pin
	output logic irqOut,
	output logic irqOe_n
);

	// ----------------------------------------
	// Address tables
	// ----------------------------------------
	localparam logic [1:0][7:0] TERM_ADDR = {`LGC_ADDR_CH2_TERM, `LGC_ADDR_CH1_TERM};
	localparam logic [1:0][7:0] JIT_ADDR = {`LGC_ADDR_CH2_JITTER, `LGC_ADDR_CH1_JITTER};

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------

	// Termination code to impedance; top bit picks external resistors
	function automatic lgc_pkg::lgc_term_t decodeTerm(input logic [2:0] code);
		lgc_pkg::lgc_term_t t;
		if (code[2]) begin
			t = lgc_pkg::LGC_TERM_EXT;
		end else begin
			unique case (code[1:0])
				2'h0: t = lgc_pkg::LGC_TERM_75;
				2'h1: t = lgc_pkg::LGC_TERM_120;
				2'h2: t = lgc_pkg::LGC_TERM_100;
				2'h3: t = lgc_pkg::LGC_TERM_110;
			endcase
		end
		return t;
	endfunction : decodeTerm

	// Placement: codes 00 and 10 leave the attenuator out
	function automatic lgc_pkg::lgc_ja_place_t decodePlace(input logic [1:0] code);
		lgc_pkg::lgc_ja_place_t p;
		if (!code[0]) begin
			p = lgc_pkg::LGC_JA_OFF;
		end else if (code[1]) begin
			p = lgc_pkg::LGC_JA_RX;
		end else begin
			p = lgc_pkg::LGC_JA_TX;
		end
		return p;
	endfunction : decodePlace

	// Elastic buffer depth in bits
	function automatic logic [7:0] decodeDepth(input logic [1:0] code);
		logic [7:0] d;
		if (code[1]) begin
			d = `LGC_DEPTH_32;
		end else if (code[0]) begin
			d = `LGC_DEPTH_64;
		end else begin
			d = `LGC_DEPTH_128;
		end
		return d;
	endfunction : decodeDepth

	// Corner depends on both the bandwidth bit and the line standard
	function automatic lgc_pkg::lgc_ja_corner_t decodeCorner(input logic bw, input logic t1);
		lgc_pkg::lgc_ja_corner_t c;
		unique case ({bw, t1})
			2'h0: c = lgc_pkg::LGC_BW_E1_6P8;
			2'h1: c = lgc_pkg::LGC_BW_T1_5;
			2'h2: c = lgc_pkg::LGC_BW_E1_0P9;
			2'h3: c = lgc_pkg::LGC_BW_T1_1P25;
		endcase
		return c;
	endfunction : decodeCorner

	// Monitor routing: codes 00 and 10 are normal
	function automatic lgc_pkg::lgc_monitor_t decodeMonitor(input logic [1:0] code);
		lgc_pkg::lgc_monitor_t m;
		if (!code[0]) begin
			m = lgc_pkg::LGC_MON_NORMAL;
		end else if (code[1]) begin
			m = lgc_pkg::LGC_MON_TX2;
		end else begin
			m = lgc_pkg::LGC_MON_RX2;
		end
		return m;
	endfunction : decodeMonitor

	// Pin style: x0 is open drain
	function automatic lgc_pkg::lgc_pin_style_t decodePin(input logic [1:0] code);
		lgc_pkg::lgc_pin_style_t s;
		if (!code[0]) begin
			s = lgc_pkg::LGC_PIN_OD_LOW;
		end else if (code[1]) begin
			s = lgc_pkg::LGC_PIN_PP_HIGH;
		end else begin
			s = lgc_pkg::LGC_PIN_PP_LOW;
		end
		return s;
	endfunction : decodePin

	// ----------------------------------------
	// State
	// ----------------------------------------
	lgc_pkg::lgc_state_t s;
	lgc_pkg::lgc_state_t next_s;
	lgc_pkg::lgc_host_req_t req;

	assign req = '{addr: hostAddr, wr: hostWr, rd: hostRd, wrData: hostWrData};

	// Register writes, reads and decoded outputs
	always_comb begin
		next_s = s;
		next_s.rdValid = 1'b0;
		next_s.swResetPulse = 1'b0;
		if (req.wr && req.addr == `LGC_ADDR_SW_RESET) begin
			// Defaults everywhere except the line standard bit
			next_s.globalCfg = (`LGC_RST_GLOBAL & ~`LGC_KEEP_GLOBAL)
				| (s.globalCfg & `LGC_KEEP_GLOBAL); // see R1, R4
			next_s.term = {2{`LGC_RST_TERM}}; // see R1
			next_s.jitter = {2{`LGC_RST_JITTER}}; // see R1
			next_s.drvHiZ = 2'h3; // see R3
			next_s.swResetPulse = 1'b1;
		end else if (req.wr) begin
			if (req.addr == `LGC_ADDR_GLOBAL) begin
				next_s.globalCfg = req.wrData & `LGC_MASK_GLOBAL; // see R19
			end
			for (int c = 0; c < 2; c++) begin
				// Own offset, or the partner's offset while broadcasting
				if (req.addr == TERM_ADDR[c] || (s.globalCfg[`LGC_BCAST_BIT]
					&& req.addr == TERM_ADDR[1 - c])) begin // see R8, R14
					next_s.term[c] = req.wrData & `LGC_MASK_TERM; // see R19
					next_s.drvHiZ[c] = 1'b0;
				end
				if (req.addr == JIT_ADDR[c] || (s.globalCfg[`LGC_BCAST_BIT]
					&& req.addr == JIT_ADDR[1 - c])) begin // see R8, R14
					next_s.jitter[c] = req.wrData & `LGC_MASK_JITTER; // see R19
				end
			end
		end
		if (req.rd) begin
			next_s.rdValid = 1'b1;
			unique case (req.addr)
				`LGC_ADDR_SW_RESET: next_s.rdData = `LGC_RST_SW_RESET; // see R2
				`LGC_ADDR_GLOBAL: next_s.rdData = s.globalCfg;
				`LGC_ADDR_IRQ_SRC: next_s.rdData = {6'h00, ~chIrq} & `LGC_MASK_IRQ_SRC; // see R11
				`LGC_ADDR_CH1_TERM: next_s.rdData = s.term[0];
				`LGC_ADDR_CH2_TERM: next_s.rdData = s.term[1];
				`LGC_ADDR_CH1_JITTER: next_s.rdData = s.jitter[0];
				`LGC_ADDR_CH2_JITTER: next_s.rdData = s.jitter[1];
				default: next_s.rdData = 8'h00;
			endcase
		end
		// Decode from the values about to be stored so outputs track writes
		next_s.monitor = decodeMonitor(next_s.globalCfg[`LGC_MON_MSB:`LGC_MON_LSB]); // see R5
		next_s.t1Mode = next_s.globalCfg[`LGC_STD_BIT]; // see R6
		next_s.irqDisable = next_s.globalCfg[`LGC_IRQ_DIS_BIT]; // see R9
		next_s.pinStyle = decodePin(next_s.globalCfg[`LGC_PIN_MSB:`LGC_PIN_LSB]); // see R10
		for (int c = 0; c < 2; c++) begin
			next_s.chCfg[c].txTerm =
				decodeTerm(next_s.term[c][`LGC_TX_TERM_MSB:`LGC_TX_TERM_LSB]); // see R12
			// External transmit resistors are an E1 option; T1/J1 falls back to 100 ohms
			if (next_s.t1Mode && next_s.chCfg[c].txTerm == lgc_pkg::LGC_TERM_EXT) begin
				next_s.chCfg[c].txTerm = lgc_pkg::LGC_TERM_100; // see R12
			end
			next_s.chCfg[c].rxTerm =
				decodeTerm(next_s.term[c][`LGC_RX_TERM_MSB:`LGC_RX_TERM_LSB]); // see R13
			next_s.chCfg[c].jaPlace =
				decodePlace(next_s.jitter[c][`LGC_JA_PLACE_MSB:`LGC_JA_PLACE_LSB]); // see R15
			next_s.chCfg[c].jaDepthBits =
				decodeDepth(next_s.jitter[c][`LGC_JA_DEPTH_MSB:`LGC_JA_DEPTH_LSB]); // see R16
			next_s.chCfg[c].jaCorner =
				decodeCorner(next_s.jitter[c][`LGC_JA_BW_BIT], next_s.t1Mode); // see R17
			next_s.chCfg[c].jaLimit = next_s.jitter[c][`LGC_JITTER_LIMIT_MODE_BIT]; // see R18
		end
	end

	// Reset image, fixed values only
	localparam lgc_pkg::lgc_chan_cfg_t CFG_RST = '{txTerm: lgc_pkg::LGC_TERM_75,
		rxTerm: lgc_pkg::LGC_TERM_75, jaPlace: lgc_pkg::LGC_JA_OFF,
		jaDepthBits: `LGC_DEPTH_128, jaCorner: lgc_pkg::LGC_BW_E1_6P8, jaLimit: 1'b1};

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '{globalCfg: `LGC_RST_GLOBAL, term: {2{`LGC_RST_TERM}},
				jitter: {2{`LGC_RST_JITTER}}, rdData: 8'h00, rdValid: 1'b0,
				drvHiZ: 2'h3, swResetPulse: 1'b0, chCfg: {2{CFG_RST}},
				monitor: lgc_pkg::LGC_MON_NORMAL, t1Mode: 1'b0, irqDisable: 1'b1,
				pinStyle: lgc_pkg::LGC_PIN_OD_LOW};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hostRdData = s.rdData;
	assign hostRdValid = s.rdValid;
	assign chanCfg = s.chCfg;
	assign monitorRoute = s.monitor;
	assign t1Mode = s.t1Mode;
	assign drvHiZ = s.drvHiZ;
	assign swResetPulse = s.swResetPulse;

	// Pin driver keeps its own registered outputs
	lgc_irq_pin uIrqPin (
		.clk(clk),
		.rst(rst),
		.chIrq(chIrq),
		.irqDisable(s.irqDisable),
		.pinStyle(s.pinStyle),
		.pinOut(irqOut),
		.pinOe_n(irqOe_n)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cbCfg @(posedge clk); endclocking
	default disable iff (rst);

	a_soft_reset_global: assert property (hostWr && hostAddr == `LGC_ADDR_SW_RESET // see R1
		|=> s.globalCfg == ((`LGC_RST_GLOBAL & ~`LGC_KEEP_GLOBAL)
		| ($past(s.globalCfg) & `LGC_KEEP_GLOBAL)))
		else $error("soft reset did not restore global settings");
	a_soft_reset_std: assert property (hostWr && hostAddr == `LGC_ADDR_SW_RESET // see R4
		|=> $stable(t1Mode) && chanCfg[1].jaLimit && chanCfg[0].jaLimit)
		else $error("line standard lost or jitter limit not restored");
	a_reset_reg_fixed: assert property (hostRd && hostAddr == `LGC_ADDR_SW_RESET // see R2
		|=> hostRdValid && hostRdData == 8'h00)
		else $error("software reset register read nonzero");
	a_drivers_hiz: assert property (hostWr && hostAddr == `LGC_ADDR_SW_RESET // see R3
		|=> drvHiZ == 2'h3 && swResetPulse)
		else $error("drivers not high impedance after soft reset");
	a_broadcast_copy: assert property (hostWr && s.globalCfg[`LGC_BCAST_BIT] // see R8
		&& hostAddr == `LGC_ADDR_CH1_JITTER
		|=> s.jitter[1] == s.jitter[0] && s.jitter[0] == ($past(hostWrData) & 8'h3F))
		else $error("broadcast write not copied to channel 2");
	a_no_broadcast: assert property (hostWr && !s.globalCfg[`LGC_BCAST_BIT] // see R14
		&& hostAddr == `LGC_ADDR_CH2_TERM |=> $stable(s.term[0]))
		else $error("channel 2 write leaked into channel 1");
	a_irq_source: assert property (hostRd && hostAddr == `LGC_ADDR_IRQ_SRC // see R11
		|=> hostRdData == {6'h00, ~$past(chIrq)})
		else $error("interrupt source register mismatch");
	a_reserved_zero: assert property (hostRd && hostAddr == `LGC_ADDR_CH2_TERM // see R19
		|=> hostRdData[7:6] == 2'h0)
		else $error("reserved termination bits read nonzero");
	a_depth_decode: assert property (s.jitter[0][`LGC_JA_DEPTH_MSB] // see R16
		|-> chanCfg[0].jaDepthBits == 8'h20)
		else $error("jitter depth not 32 bits for code 1x");
	a_monitor_route: assert property (s.globalCfg[7:6] == 2'h3 // see R5
		|-> monitorRoute == lgc_pkg::LGC_MON_TX2)
		else $error("monitor route wrong for code 11");

	// ----------------------------------------
	// Global and decoded field checks
	// ----------------------------------------
	a_std_select: assert property (hostWr && hostAddr == `LGC_ADDR_GLOBAL // see R6
		|=> t1Mode == $past(hostWrData[`LGC_STD_BIT]))
		else $error("line standard not taken from write");
	a_global_mask: assert property (hostWr && hostAddr == `LGC_ADDR_GLOBAL // see R19
		|=> s.globalCfg == ($past(hostWrData) & `LGC_MASK_GLOBAL))
		else $error("global register stored reserved bit");
	a_irq_disable_bit: assert property (hostWr && hostAddr == `LGC_ADDR_GLOBAL // see R9
		|=> s.irqDisable == $past(hostWrData[`LGC_IRQ_DIS_BIT]))
		else $error("interrupt disable not taken from write");
	a_term_broadcast: assert property (hostWr && s.globalCfg[`LGC_BCAST_BIT] // see R8
		&& hostAddr == `LGC_ADDR_CH2_TERM
		|=> s.term[0] == ($past(hostWrData) & `LGC_MASK_TERM) && drvHiZ == 2'h0)
		else $error("broadcast termination not copied to channel 1");
	a_term_write: assert property (hostWr && hostAddr == `LGC_ADDR_CH1_TERM // see R14
		|=> s.term[0] == ($past(hostWrData) & `LGC_MASK_TERM) && !drvHiZ[0])
		else $error("channel 1 termination write lost");
	a_tx_ext_e1: assert property (s.term[0][`LGC_TX_TERM_MSB] && !t1Mode // see R12
		|-> chanCfg[0].txTerm == lgc_pkg::LGC_TERM_EXT)
		else $error("external transmit termination not selected in E1");
	a_tx_ext_t1: assert property (s.term[0][`LGC_TX_TERM_MSB] && t1Mode // see R12
		|-> chanCfg[0].txTerm == lgc_pkg::LGC_TERM_100)
		else $error("external transmit termination used in T1/J1");
	a_rx_ext: assert property (s.term[0][`LGC_RX_TERM_MSB] // see R13
		|-> chanCfg[0].rxTerm == lgc_pkg::LGC_TERM_EXT)
		else $error("external receive termination not selected");
	a_rx_120: assert property (s.term[0][2:0] == 3'h1 // see R13
		|-> chanCfg[0].rxTerm == lgc_pkg::LGC_TERM_120)
		else $error("receive termination not 120 ohm for code 001");
	a_place_rx: assert property (s.jitter[1][4:3] == 2'h3 // see R15
		|-> chanCfg[1].jaPlace == lgc_pkg::LGC_JA_RX)
		else $error("attenuator not in receive path for code 11");
	a_place_off: assert property (!s.jitter[0][`LGC_JA_PLACE_LSB] // see R15
		|-> chanCfg[0].jaPlace == lgc_pkg::LGC_JA_OFF)
		else $error("attenuator in use for code x0");
	a_corner_t1: assert property (s.jitter[1][`LGC_JA_BW_BIT] && t1Mode // see R17
		|-> chanCfg[1].jaCorner == lgc_pkg::LGC_BW_T1_1P25)
		else $error("jitter corner wrong for T1/J1 narrow band");
	a_limit_bit: assert property (hostWr && hostAddr == `LGC_ADDR_CH2_JITTER // see R18
		|=> chanCfg[1].jaLimit == $past(hostWrData[`LGC_JITTER_LIMIT_MODE_BIT]))
		else $error("jitter limit mode not taken from write");
	a_depth_64: assert property (s.jitter[1][2:1] == 2'h1 // see R16
		|-> chanCfg[1].jaDepthBits == 8'h40)
		else $error("jitter depth not 64 bits for code 01");
	a_monitor_rx2: assert property (s.globalCfg[7:6] == 2'h1 // see R5
		|-> monitorRoute == lgc_pkg::LGC_MON_RX2)
		else $error("monitor route wrong for code 01");

endmodule : lgc_config

`default_nettype wire

// File: verif/lgc_host_model.sv
// Purpose: Host processor model on the register port of the configuration bank.
// Assumes: One-cycle strobes launched just after a rising edge.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none

module lgc_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] hostAddr,
	output logic hostWr,
	output logic hostRd,
	output logic [7:0] hostWrData,
	input wire logic [7:0] hostRdData,
	input wire logic hostRdValid
);
	// ----------------------------------------
	// Bus state
	// ----------------------------------------
	localparam int SETTLE = 5000;
	logic stdShadow;

	// Idle bus at time zero
	initial begin
		hostAddr = 8'h00;
		hostWr = 1'b0;
		hostRd = 1'b0;
		hostWrData = 8'h00;
		stdShadow = 1'b0;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	// Write; a line standard change is waited out since clocking resettles
	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hostAddr <= a;
		hostWrData <= d;
		hostWr <= 1'b1;
		@(posedge clk);
		hostWr <= 1'b0;
		hostAddr <= ~a;
		hostWrData <= ~d;
		if (a === 8'h20 && d[4] !== stdShadow) begin
			stdShadow = d[4];
			repeat (SETTLE) @(posedge clk);
		end
		// Return off the edge so callers see the registered result
		#1;
	endtask : wrReg

	// Read; the answer is sampled once it has settled after the taking edge
	task automatic rdReg(input logic [7:0] a, output logic [7:0] q, output logic v);
		@(posedge clk);
		hostAddr <= a;
		hostRd <= 1'b1;
		@(posedge clk);
		hostRd <= 1'b0;
		hostAddr <= ~a;
		#1;
		q = hostRdData;
		v = hostRdValid;
	endtask : rdReg

endmodule : lgc_host_model
`default_nettype wire

// File: verif/lgc_config_test.sv
// Purpose: Self-checking bench of the configuration bank.
// Assumes: Host model tasks for every register access.
// Notes:   Line standard changes cost the host a long settle wait.
`timescale 1ns/1ps
`default_nettype none

module lgc_config_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk;
	logic rst;
	logic [7:0] hostAddr;
	logic hostWr;
	logic hostRd;
	logic [7:0] hostWrData;
	logic [7:0] hostRdData;
	logic hostRdValid;
	logic [1:0] chIrq;
	lgc_pkg::lgc_chan_cfg_t [1:0] chanCfg;
	lgc_pkg::lgc_monitor_t monitorRoute;
	lgc_pkg::lgc_monitor_t expMon;
	logic t1Mode;
	logic [1:0] drvHiZ;
	logic swResetPulse;
	logic irqOut;
	logic irqOe_n;
	logic t1Exp = 1'b0;
	int failures = 0;
	int compares = 0;
	int cycles = 0;

	lgc_config uut (.clk(clk), .rst(rst), .hostAddr(hostAddr), .hostWr(hostWr),
		.hostRd(hostRd), .hostWrData(hostWrData), .hostRdData(hostRdData),
		.hostRdValid(hostRdValid), .chIrq(chIrq), .chanCfg(chanCfg),
		.monitorRoute(monitorRoute), .t1Mode(t1Mode), .drvHiZ(drvHiZ),
		.swResetPulse(swResetPulse), .irqOut(irqOut), .irqOe_n(irqOe_n));

	lgc_host_model host (.clk(clk), .hostAddr(hostAddr), .hostWr(hostWr), .hostRd(hostRd),
		.hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid));

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run needs about 5900 cycles; the ceiling leaves ample room
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			failures = failures + 1;
			results();
		end
	end

	// ----------------------------------------
	// Compare tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chkRd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		logic v;
		host.rdReg(a, q, v);
		chk("read valid", 8'h01, {7'h00, v});
		chk($sformatf("register %h", a), exp, q);
	endtask : chkRd

	// Expected decode from the stored codes and the standard the bench set
	task automatic chkCfg(input int c, input logic [7:0] t, input logic [7:0] j);
		lgc_pkg::lgc_chan_cfg_t e;
		e.txTerm = lgc_pkg::lgc_term_t'({1'b0, t[4:3]});
		if (t[5]) e.txTerm = t1Exp ? lgc_pkg::LGC_TERM_100 : lgc_pkg::LGC_TERM_EXT;
		e.rxTerm = t[2] ? lgc_pkg::LGC_TERM_EXT : lgc_pkg::lgc_term_t'({1'b0, t[1:0]});
		e.jaPlace = !j[3] ? lgc_pkg::LGC_JA_OFF : j[4] ? lgc_pkg::LGC_JA_RX : lgc_pkg::LGC_JA_TX;
		e.jaDepthBits = j[2] ? 8'h20 : j[1] ? 8'h40 : 8'h80;
		e.jaCorner = t1Exp ? (j[0] ? lgc_pkg::LGC_BW_T1_1P25 : lgc_pkg::LGC_BW_T1_5) :
			(j[0] ? lgc_pkg::LGC_BW_E1_0P9 : lgc_pkg::LGC_BW_E1_6P8);
		e.jaLimit = j[5];
		compares = compares + 1;
		if (chanCfg[c] !== e) begin
			failures = failures + 1;
			$display("BAD channel %0d config expected %h seen %h", c, e, chanCfg[c]);
		end
	endtask : chkCfg

	task automatic results();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		chIrq = 2'b00;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Defaults after power-up reset
		chkRd(8'h20, 8'h04);
		chkRd(8'h22, 8'h00);
		chkRd(8'h03, 8'h20);
		chkRd(8'h01, 8'h00);
		chkRd(8'h21, 8'h03);
		chk("hiz", 8'h03, {6'h00, drvHiZ});
		chkCfg(1, 8'h00, 8'h20);
		// Every termination and jitter code, in E1 then T1/J1
		for (int m = 0; m < 2; m++) begin
			t1Exp = m[0];
			host.wrReg(8'h20, {3'b000, t1Exp, 4'h4});
			chk("standard", {7'h00, t1Exp}, {7'h00, t1Mode});
			for (int v = 0; v < 64; v++) begin
				host.wrReg(8'h02, 8'(v) | 8'hC0);
				host.wrReg(8'h23, 8'(v) | 8'hC0);
				chkCfg(0, 8'(v), 8'h20);
				chkCfg(1, 8'h00, 8'(v));
				chkRd(8'h02, 8'(v));
			end
		end
		chkRd(8'h23, 8'h3F);
		chk("hiz", 8'h02, {6'h00, drvHiZ});
		// Global register reserved bit and monitor codes
		host.wrReg(8'h20, 8'hFF);
		chkRd(8'h20, 8'hDF);
		for (int k = 0; k < 4; k++) begin
			host.wrReg(8'h20, {2'(k), 6'h14});
			expMon = k == 1 ? lgc_pkg::LGC_MON_RX2 : lgc_pkg::LGC_MON_NORMAL;
			if (k == 3) expMon = lgc_pkg::LGC_MON_TX2;
			chk("monitor", {6'h00, expMon}, {6'h00, monitorRoute});
		end
		// Broadcast on, then off
		host.wrReg(8'h20, 8'h1C);
		host.wrReg(8'h22, 8'h09);
		host.wrReg(8'h03, 8'h2D);
		chkRd(8'h02, 8'h09);
		chkRd(8'h23, 8'h2D);
		chk("hiz", 8'h00, {6'h00, drvHiZ});
		host.wrReg(8'h20, 8'h14);
		host.wrReg(8'h22, 8'h12);
		chkRd(8'h02, 8'h09);
		chkRd(8'h22, 8'h12);
		// Interrupt source and pin while globally disabled
		@(posedge clk);
		chIrq <= 2'b01;
		repeat (3) @(posedge clk);
		#1;
		chk("pin oe", 8'h01, {7'h00, irqOe_n});
		host.wrReg(8'h21, 8'h00);
		chkRd(8'h21, 8'h02);
		// Every pin style, source idle and active
		for (int s = 0; s < 8; s++) begin
			@(posedge clk);
			chIrq <= {s[2], 1'b0};
			host.wrReg(8'h20, {6'h04, s[1:0]});
			repeat (2) @(posedge clk);
			#1;
			chk("pin oe", {7'h00, !s[0] && !s[2]}, {7'h00, irqOe_n});
			if (s[0] || s[2]) chk("pin out", {7'h00, s[0] && (s[1] == s[2])}, {7'h00, irqOut});
		end
		host.wrReg(8'h20, 8'h17);
		repeat (2) @(posedge clk);
		#1;
		chk("pin out", 8'h00, {7'h00, irqOut});
		// Software reset keeps only the line standard
		host.wrReg(8'h01, 8'h5A);
		#1;
		chk("soft pulse", 8'h01, {7'h00, swResetPulse});
		@(posedge clk);
		#1;
		chk("soft pulse", 8'h00, {7'h00, swResetPulse});
		chk("hiz", 8'h03, {6'h00, drvHiZ});
		chk("standard", 8'h01, {7'h00, t1Mode});
		chk("pin oe", 8'h01, {7'h00, irqOe_n});
		chkRd(8'h20, 8'h14);
		chkRd(8'h02, 8'h00);
		chkRd(8'h23, 8'h20);
		chkRd(8'h01, 8'h00);
		chkCfg(0, 8'h00, 8'h20);
		results();
	end

endmodule : lgc_config_test
`default_nettype wire
